// ### fmpg_and_tree.sv
`timescale 1ns/1ns
module fmpg_and_tree #(
	parameter int N = 8
) (
	input  wire logic [N-1:0] i_good,
	input  wire logic [N-1:0] i_exclude,
	output logic              o_all_good
);
	// Excluded inputs count as good
	assign o_all_good = &(i_good | i_exclude);
endmodule

// ### fmpg_host.sv
`timescale 1ns/1ns
module fmpg_host (
	input  wire logic                 i_core_clk,
	input  wire fmpg_pkg::fmpg_byte_t i_rdata,
	input  wire logic                 i_rvalid,
	output logic                      o_wr_en,
	output logic                      o_rd_en,
	output logic [7:0]                o_addr,
	output logic [7:0]                o_wdata
);
	import fmpg_pkg::*;
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr  = 8'h00;
		o_wdata = 8'h00;
	end
	// One access; idle address and data show the inverse
	task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q, output logic v);
		logic [7:0] w;
		w = (a == 8'hA3) ? ((d & 8'h9F) | 8'h20) : d;
		@(posedge i_core_clk);
		o_wr_en <= wr;
		o_rd_en <= ~wr;
		o_addr  <= a;
		o_wdata <= w;
		@(posedge i_core_clk);
		o_wr_en <= 1'b0;
		o_rd_en <= 1'b0;
		o_addr  <= ~a;
		o_wdata <= ~w;
		#1;
		q = i_rdata;
		v = i_rvalid;
	endtask
endmodule

// ### fmpg_pkg.sv
package fmpg_pkg;
	typedef logic [7:0] fmpg_byte_t;
	typedef enum logic [1:0] {
		FMPG_LOAD = 2'b01,
		FMPG_RUN  = 2'b10
	} fmpg_state_t;
endpackage

// ### fmpg_regs.svh
`ifndef FMPG_REGS_SVH
`define FMPG_REGS_SVH

`define FMPG_OFS_FAULT_MASK_B 8'hA3
`define FMPG_OFS_PG_SEL_A     8'hA4
`define FMPG_OFS_PG_SEL_B     8'hA5

`define FMPG_FM_AUX1_BIT      4
`define FMPG_FM_TERM_BIT      3
`define FMPG_FM_LOAD_SWITCH_B_SECOND_BIT      2
`define FMPG_FM_LOAD_SWITCH_B_FIRST_BIT      1
`define FMPG_FM_AUX3_BIT      0
`define FMPG_FM_RSV6_BIT      6
`define FMPG_FM_RSV5_BIT      5
`define FMPG_FM_RO_MASK       8'h80

`define FMPG_SA_AUX2_BIT      7
`define FMPG_SA_SWA_BIT       6
`define FMPG_SA_SD6_BIT       5
`define FMPG_SA_SD5_BIT       4
`define FMPG_SA_SD4_BIT       3
`define FMPG_SA_SD3_BIT       2
`define FMPG_SA_SD2_BIT       1
`define FMPG_SA_SD1_BIT       0

`define FMPG_SB_CTL5_BIT      7
`define FMPG_SB_CTL4_BIT      6
`define FMPG_SB_CTL2_BIT      5
`define FMPG_SB_CONTROL_INPUT_1_BIT      4
`define FMPG_SB_TERM_BIT      3
`define FMPG_SB_SHR_BIT       2
`define FMPG_SB_LOAD_SWITCH_B_FIRST_BIT      1
`define FMPG_SB_AUX3_BIT      0

`define FMPG_RST_REG          8'h00

`endif

// ### fmpg_top.sv
`timescale 1ns/1ns
`include "fmpg_regs.svh"
// Function
// - Mask bit4 blocks aux reg1 fault shutdown
// - Mask bit3 blocks term reg fault shutdown
// - Mask bit2 blocks switch B2 fault shutdown
// - Mask bit1 blocks switch B1 fault shutdown
// - Mask bit0 blocks aux reg3 fault shutdown
// - Select A bit7 excludes aux reg2 good
// - Select A bit6 excludes switch A good
// - Select A bits5..3 exclude stepdown 6..4
// - Select A bits2..0 exclude stepdown 3..1
// - Select B bits7,6 exclude control pins 5,4
// - Select B bits5,4 exclude control pins 2,1
// - Select B bit3 excludes term reg good
// - Select B bit2 excludes shared rail good
// - Select B bit1 excludes switch B1 good
// - Select B bit0 excludes aux reg3 good
module fmpg_top (
	input  wire logic              i_core_clk,
	input  wire logic              i_rst,
	input  wire logic              i_otp_valid,
	input  wire fmpg_pkg::fmpg_byte_t i_otp_fault_mask_b,
	input  wire fmpg_pkg::fmpg_byte_t i_otp_pg_sel_a,
	input  wire fmpg_pkg::fmpg_byte_t i_otp_pg_sel_b,
	input  wire logic              i_wr_en,
	input  wire logic              i_rd_en,
	input  wire logic [7:0]        i_addr,
	input  wire fmpg_pkg::fmpg_byte_t i_wdata,
	output fmpg_pkg::fmpg_byte_t   o_rdata,
	output logic                   o_rvalid,
	input  wire logic              i_aux_reg_1_fault,
	input  wire logic              i_term_reg_fault,
	input  wire logic              i_load_switch_b_second_fault,
	input  wire logic              i_load_switch_b_first_fault,
	input  wire logic              i_aux_reg_3_fault,
	input  wire logic [5:0]        i_stepdown_rail_pg,
	input  wire logic              i_load_switch_a_pg,
	input  wire logic              i_aux_reg_2_pg,
	input  wire logic              i_aux_reg_3_pg,
	input  wire logic              i_load_switch_b_first_pg,
	input  wire logic              i_shared_rail_pg,
	input  wire logic              i_term_reg_pg,
	input  wire logic [3:0]        i_control_input,
	output logic [4:0]             o_shutdown_enable,
	output logic                   o_fault_shutdown,
	output logic                   o_pgood_out_1,
	output logic                   o_cfg_loaded
);
	import fmpg_pkg::*;

	typedef struct packed {
		fmpg_state_t state;
		fmpg_byte_t  fault_mask_b;
		fmpg_byte_t  pg_sel_a;
		fmpg_byte_t  pg_sel_b;
		fmpg_byte_t  rdata;
		logic        rvalid;
		logic [4:0]  shdn_en;
		logic        fault_shdn;
		logic        pgood;
		logic        loaded;
	} fmpg_core_t;

	fmpg_core_t cur;
	fmpg_core_t next_cur;
	logic       tree_good;
	logic [4:0] fault_vec;
	logic [7:0] pg_sel_a_in;
	logic [7:0] pg_sel_b_in;

	// Order follows select register bit positions
	assign pg_sel_a_in = {i_aux_reg_2_pg, i_load_switch_a_pg,
		i_stepdown_rail_pg[5], i_stepdown_rail_pg[4], i_stepdown_rail_pg[3],
		i_stepdown_rail_pg[2], i_stepdown_rail_pg[1], i_stepdown_rail_pg[0]};
	assign pg_sel_b_in = {i_control_input[3], i_control_input[2],
		i_control_input[1], i_control_input[0], i_term_reg_pg,
		i_shared_rail_pg, i_load_switch_b_first_pg, i_aux_reg_3_pg};
	assign fault_vec = {i_aux_reg_1_fault, i_term_reg_fault,
		i_load_switch_b_second_fault, i_load_switch_b_first_fault, i_aux_reg_3_fault};

	// Both select registers feed one good tree
	fmpg_and_tree #(
		.N (16)
	) u_tree (
		.i_good     ({pg_sel_b_in, pg_sel_a_in}),
		.i_exclude  ({cur.pg_sel_b, cur.pg_sel_a}),
		.o_all_good (tree_good)
	);

	always_comb begin
		next_cur = cur;
		next_cur.rvalid = 1'b0;
		case (cur.state)
			FMPG_LOAD: begin
				if (i_otp_valid) begin
					next_cur.fault_mask_b = i_otp_fault_mask_b & ~`FMPG_FM_RO_MASK;
					next_cur.pg_sel_a = i_otp_pg_sel_a;
					next_cur.pg_sel_b = i_otp_pg_sel_b;
					next_cur.loaded = 1'b1;
					next_cur.state = FMPG_RUN;
				end
			end
			FMPG_RUN: begin
				if (i_wr_en) begin
					case (i_addr)
						`FMPG_OFS_FAULT_MASK_B: begin
							// Reserved bits 6,5 stored as written by host
							next_cur.fault_mask_b = i_wdata & ~`FMPG_FM_RO_MASK;
						end
						`FMPG_OFS_PG_SEL_A: begin
							next_cur.pg_sel_a = i_wdata;
						end
						`FMPG_OFS_PG_SEL_B: begin
							next_cur.pg_sel_b = i_wdata;
						end
						default: begin
						end
					endcase
				end
				if (i_rd_en) begin
					next_cur.rvalid = 1'b1;
					case (i_addr)
						`FMPG_OFS_FAULT_MASK_B: next_cur.rdata = cur.fault_mask_b;
						`FMPG_OFS_PG_SEL_A:     next_cur.rdata = cur.pg_sel_a;
						`FMPG_OFS_PG_SEL_B:     next_cur.rdata = cur.pg_sel_b;
						default:                next_cur.rdata = 8'h00;
					endcase
				end
			end
			default: begin
				next_cur.state = FMPG_LOAD;
			end
		endcase
		// Mask bit set means fault may not shut down
		next_cur.shdn_en[4] = ~cur.fault_mask_b[`FMPG_FM_AUX1_BIT];
		next_cur.shdn_en[3] = ~cur.fault_mask_b[`FMPG_FM_TERM_BIT];
		next_cur.shdn_en[2] = ~cur.fault_mask_b[`FMPG_FM_LOAD_SWITCH_B_SECOND_BIT];
		next_cur.shdn_en[1] = ~cur.fault_mask_b[`FMPG_FM_LOAD_SWITCH_B_FIRST_BIT];
		next_cur.shdn_en[0] = ~cur.fault_mask_b[`FMPG_FM_AUX3_BIT];
		next_cur.fault_shdn = cur.loaded & |(fault_vec & cur.shdn_en);
		// Tree covers both select registers
		next_cur.pgood = cur.loaded & tree_good;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cur.state <= FMPG_LOAD;
			cur.fault_mask_b <= `FMPG_RST_REG;
			cur.pg_sel_a <= `FMPG_RST_REG;
			cur.pg_sel_b <= `FMPG_RST_REG;
			cur.rdata <= 8'h00;
			cur.rvalid <= 1'b0;
			cur.shdn_en <= 5'h1F;
			cur.fault_shdn <= 1'b0;
			cur.pgood <= 1'b0;
			cur.loaded <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

	assign o_rdata = cur.rdata;
	assign o_rvalid = cur.rvalid;
	assign o_shutdown_enable = cur.shdn_en;
	assign o_fault_shutdown = cur.fault_shdn;
	assign o_pgood_out_1 = cur.pgood;
	assign o_cfg_loaded = cur.loaded;

	aux1_mask_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.loaded && i_aux_reg_1_fault && !cur.fault_mask_b[4] && cur.shdn_en[4])
		|=> o_fault_shutdown)
		else $error("aux reg1 fault did not shut down");
	term_mask_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(cur.fault_mask_b[3]) |=> !o_shutdown_enable[3])
		else $error("term reg mask not applied");
	load_switch_b_second_mask_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$fell(cur.fault_mask_b[2]) |=> o_shutdown_enable[2])
		else $error("switch b2 mask not cleared");
	load_switch_b_first_mask_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.fault_mask_b[1] && cur.shdn_en[1:0] == 2'b00 && cur.shdn_en[4:2] == 3'b000)
		|=> !o_fault_shutdown)
		else $error("masked faults caused shutdown");
	aux3_mask_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.loaded && i_aux_reg_3_fault && cur.shdn_en[0]) |=> o_fault_shutdown)
		else $error("aux reg3 fault ignored");
	pg_tree_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.loaded && (&(pg_sel_a_in | cur.pg_sel_a)) && (&(pg_sel_b_in | cur.pg_sel_b)))
		|=> o_pgood_out_1)
		else $error("power good output low with all good");
	pg_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_aux_reg_2_pg && !cur.pg_sel_a[7]) |=> !o_pgood_out_1)
		else $error("aux reg2 bad not reflected");
	ctl_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_control_input[3] && !cur.pg_sel_b[7]) |=> !o_pgood_out_1)
		else $error("control pin5 low not reflected");
	bit7_zero_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_rd_en && cur.state == FMPG_RUN && i_addr == `FMPG_OFS_FAULT_MASK_B
		|=> o_rvalid && !o_rdata[7])
		else $error("mask bit7 not zero");

	// Included bad inputs pull the tree low
	swa_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_load_switch_a_pg && !cur.pg_sel_a[`FMPG_SA_SWA_BIT]) |=> !o_pgood_out_1)
		else $error("switch a bad not reflected");
	sd6_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_stepdown_rail_pg[5] && !cur.pg_sel_a[`FMPG_SA_SD6_BIT]) |=> !o_pgood_out_1)
		else $error("stepdown6 bad not reflected");
	sd5_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_stepdown_rail_pg[4] && !cur.pg_sel_a[`FMPG_SA_SD5_BIT]) |=> !o_pgood_out_1)
		else $error("stepdown5 bad not reflected");
	sd4_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_stepdown_rail_pg[3] && !cur.pg_sel_a[`FMPG_SA_SD4_BIT]) |=> !o_pgood_out_1)
		else $error("stepdown4 bad not reflected");
	sd3_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_stepdown_rail_pg[2] && !cur.pg_sel_a[`FMPG_SA_SD3_BIT]) |=> !o_pgood_out_1)
		else $error("stepdown3 bad not reflected");
	sd2_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_stepdown_rail_pg[1] && !cur.pg_sel_a[`FMPG_SA_SD2_BIT]) |=> !o_pgood_out_1)
		else $error("stepdown2 bad not reflected");
	sd1_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_stepdown_rail_pg[0] && !cur.pg_sel_a[`FMPG_SA_SD1_BIT]) |=> !o_pgood_out_1)
		else $error("stepdown1 bad not reflected");
	ctl4_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_control_input[2] && !cur.pg_sel_b[`FMPG_SB_CTL4_BIT]) |=> !o_pgood_out_1)
		else $error("control pin4 low not reflected");
	ctl2_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_control_input[1] && !cur.pg_sel_b[`FMPG_SB_CTL2_BIT]) |=> !o_pgood_out_1)
		else $error("control pin2 low not reflected");
	control_input_1_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_control_input[0] && !cur.pg_sel_b[`FMPG_SB_CONTROL_INPUT_1_BIT]) |=> !o_pgood_out_1)
		else $error("control pin1 low not reflected");
	term_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_term_reg_pg && !cur.pg_sel_b[`FMPG_SB_TERM_BIT]) |=> !o_pgood_out_1)
		else $error("term reg bad not reflected");
	shared_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_shared_rail_pg && !cur.pg_sel_b[`FMPG_SB_SHR_BIT]) |=> !o_pgood_out_1)
		else $error("shared rail bad not reflected");
	load_switch_b_first_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_load_switch_b_first_pg && !cur.pg_sel_b[`FMPG_SB_LOAD_SWITCH_B_FIRST_BIT]) |=> !o_pgood_out_1)
		else $error("switch b1 bad not reflected");
	aux3_bad_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(!i_aux_reg_3_pg && !cur.pg_sel_b[`FMPG_SB_AUX3_BIT]) |=> !o_pgood_out_1)
		else $error("aux reg3 bad not reflected");

	// Writes land in the addressed register
	mask_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.state == FMPG_RUN && i_wr_en && i_addr == `FMPG_OFS_FAULT_MASK_B)
		|=> cur.fault_mask_b == ($past(i_wdata) & 8'h7F))
		else $error("fault mask write lost");
	sel_a_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.state == FMPG_RUN && i_wr_en && i_addr == `FMPG_OFS_PG_SEL_A)
		|=> cur.pg_sel_a == $past(i_wdata))
		else $error("select a write lost");
	sel_b_write_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.state == FMPG_RUN && i_wr_en && i_addr == `FMPG_OFS_PG_SEL_B)
		|=> cur.pg_sel_b == $past(i_wdata))
		else $error("select b write lost");

	// Reads return the stored value
	sel_a_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.state == FMPG_RUN && i_rd_en && i_addr == `FMPG_OFS_PG_SEL_A)
		|=> o_rvalid && o_rdata == $past(cur.pg_sel_a))
		else $error("select a read wrong");
	sel_b_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.state == FMPG_RUN && i_rd_en && i_addr == `FMPG_OFS_PG_SEL_B)
		|=> o_rvalid && o_rdata == $past(cur.pg_sel_b))
		else $error("select b read wrong");
	mask_read_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.state == FMPG_RUN && i_rd_en && i_addr == `FMPG_OFS_FAULT_MASK_B)
		|=> o_rdata == $past(cur.fault_mask_b))
		else $error("fault mask read wrong");

	// Shutdown enables follow the mask bits
	aux1_en_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		1'b1 |=> o_shutdown_enable[4] == !$past(cur.fault_mask_b[4]))
		else $error("aux reg1 enable wrong");
	term_en_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		1'b1 |=> o_shutdown_enable[3] == !$past(cur.fault_mask_b[3]))
		else $error("term reg enable wrong");
	load_switch_b_second_en_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		1'b1 |=> o_shutdown_enable[2] == !$past(cur.fault_mask_b[2]))
		else $error("switch b2 enable wrong");
	load_switch_b_first_en_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		1'b1 |=> o_shutdown_enable[1] == !$past(cur.fault_mask_b[1]))
		else $error("switch b1 enable wrong");
	aux3_en_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		1'b1 |=> o_shutdown_enable[0] == !$past(cur.fault_mask_b[0]))
		else $error("aux reg3 enable wrong");

	// Unmasked faults shut down, masked ones never
	term_flt_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.loaded && i_term_reg_fault && cur.shdn_en[3]) |=> o_fault_shutdown)
		else $error("term reg fault ignored");
	load_switch_b_second_flt_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.loaded && i_load_switch_b_second_fault && cur.shdn_en[2]) |=> o_fault_shutdown)
		else $error("switch b2 fault ignored");
	load_switch_b_first_flt_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(cur.loaded && i_load_switch_b_first_fault && cur.shdn_en[1]) |=> o_fault_shutdown)
		else $error("switch b1 fault ignored");
	masked_flt_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		((fault_vec & cur.shdn_en) == 5'h00) |=> !o_fault_shutdown)
		else $error("masked fault caused shutdown");
endmodule

// ### tb_fault_mask_and_pgood_tree.sv
`timescale 1ns/1ns
module tb_fault_mask_and_pgood_tree;
	import fmpg_pkg::*;
	logic        clk        = 1'b0;
	logic        rst        = 1'b1;
	logic        otp_valid  = 1'b0;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	fmpg_byte_t  rdata;
	logic        rvalid;
	logic [4:0]  flt        = 5'h00;
	logic [15:0] g          = 16'hFFFF;
	logic [4:0]  sd_en;
	logic        fault_sd;
	logic        pgood;
	logic        loaded;
	logic [7:0]  q;
	logic        v;
	int          err_total  = 0;
	int          num_checks = 0;
	always #4 clk = ~clk;
	fmpg_host host (.i_core_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr_en(wr_en),
		.o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata));
	fmpg_top dut (.i_core_clk(clk), .i_rst(rst), .i_otp_valid(otp_valid),
		.i_otp_fault_mask_b(8'hB5), .i_otp_pg_sel_a(8'h0F), .i_otp_pg_sel_b(8'hF0),
		.i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
		.o_rvalid(rvalid), .i_aux_reg_1_fault(flt[4]), .i_term_reg_fault(flt[3]),
		.i_load_switch_b_second_fault(flt[2]), .i_load_switch_b_first_fault(flt[1]),
		.i_aux_reg_3_fault(flt[0]), .i_stepdown_rail_pg(g[5:0]), .i_load_switch_a_pg(g[6]),
		.i_aux_reg_2_pg(g[7]), .i_aux_reg_3_pg(g[8]), .i_load_switch_b_first_pg(g[9]),
		.i_shared_rail_pg(g[10]), .i_term_reg_pg(g[11]), .i_control_input(g[15:12]),
		.o_shutdown_enable(sd_en), .o_fault_shutdown(fault_sd), .o_pgood_out_1(pgood),
		.o_cfg_loaded(loaded));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, s);
			err_total++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.access(1'b1, a, d, q, v);
	endtask
	task automatic rd(input logic [7:0] a);
		host.access(1'b0, a, 8'h00, q, v);
	endtask
	task automatic settle;
		@(posedge clk);
		#1;
	endtask
	task automatic t_load;
		repeat (8) @(posedge clk);
		#1;
		chk("shutdown_enable", 8'h1F, {3'h0, sd_en});
		@(posedge clk);
		rst       <= 1'b0;
		otp_valid <= 1'b1;
		repeat (3) settle;
		chk("cfg_loaded", 8'h01, {7'h00, loaded});
		rd(8'hA3);
		chk("fault_mask_b", 8'h35, q);
		chk("shutdown_enable", 8'h0A, {3'h0, sd_en});
		$display("test load done");
	endtask
	task automatic t_regs;
		wr(8'hA3, 8'hFF);
		rd(8'hA3);
		chk("fault_mask_b", 8'h3F, q);
		wr(8'hA4, 8'h5A);
		wr(8'hA5, 8'hC3);
		rd(8'hA4);
		chk("pgood_sel_a", 8'h5A, q);
		rd(8'hA5);
		chk("pgood_sel_b", 8'hC3, q);
		wr(8'hA6, 8'h77);
		rd(8'hA6);
		chk("unmapped", 8'h00, q);
		chk("rvalid", 8'h01, {7'h00, v});
		$display("test regs done");
	endtask
	task automatic t_fault;
		for (int i = 0; i < 5; i++) begin
			wr(8'hA3, 8'h01 << i);
			@(posedge clk);
			flt <= 5'h1F;
			settle;
			chk("shutdown_enable", ~(8'h01 << i) & 8'h1F, {3'h0, sd_en});
			chk("fault_shutdown", 8'h01, {7'h00, fault_sd});
			@(posedge clk);
			flt <= 5'h01 << i;
			settle;
			chk("fault_shutdown", 8'h00, {7'h00, fault_sd});
		end
		$display("test fault done");
	endtask
	task automatic t_pg;
		logic [15:0] m;
		for (int k = 0; k < 17; k++) begin
			m = (k < 16) ? 16'h0001 << k : 16'hFFFF;
			@(posedge clk);
			g <= ~m;
			wr(8'hA4, 8'h00);
			wr(8'hA5, 8'h00);
			settle;
			chk("pgood", 8'h00, {7'h00, pgood});
			wr(8'hA4, m[7:0]);
			wr(8'hA5, m[15:8]);
			settle;
			chk("pgood", 8'h01, {7'h00, pgood});
			chk("pgood", 8'h01, {7'h00, pgood});
		end
		$display("test pgood done");
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		t_load();
		t_regs();
		t_fault();
		t_pg();
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_of_test();
	end
endmodule
